//--- logic/dpr_pkg.sv
// Purpose: constants and types for the DMA progress readback block
// Assumes: one clock domain, transfer sizes of 1, 2 or 4 bytes
// Notes: size codes follow the usual byte/half/word encoding
package dpr_pkg;
    localparam int DPR_ADDR_W = 32;
    localparam int DPR_CNT_W = 32;
    localparam int DPR_INFL_W = 4;
    localparam int DPR_MAX_INFL = 8;
    localparam logic [1:0] DPR_SIZE_BYTE = 2'h0;
    localparam logic [1:0] DPR_SIZE_HALF = 2'h1;
    localparam logic [1:0] DPR_SIZE_WORD = 2'h2;
    localparam logic [3:0] DPR_RING_OFF = 4'h0;
    localparam logic [31:0] DPR_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] DPR_CNT_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        DPR_IDLE = 2'b00,
        DPR_RUN = 2'b01,
        DPR_DRAIN = 2'b10
    } dpr_state_e;

    // Bytes moved by one transfer of the given size code
    function automatic logic [31:0] dpr_bytes(input logic [1:0] size);
        case (size)
            DPR_SIZE_BYTE: dpr_bytes = 32'h0000_0001;
            DPR_SIZE_HALF: dpr_bytes = 32'h0000_0002;
            default: dpr_bytes = 32'h0000_0004;
        endcase
    endfunction
endpackage

//--- logic/dpr_infl_if.sv
// Purpose: carrier between the channel and one in-flight counter
// Assumes: single clock
// Notes: issue and done are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface dpr_infl_if;
    logic issue;
    logic done;
    logic [3:0] count;
    logic busy;
    modport ctl (output issue, output done, input count, input busy);
    modport cnt (input issue, input done, output count, output busy);
endinterface
`default_nettype wire

//--- logic/dpr_infl_cnt.sv
// Purpose: counts transfers issued to the bus pipeline and not yet completed
// Assumes: done never arrives while the count is zero
// Notes: issue and done in one cycle leave a nonzero count unchanged; at zero the issue still counts
`timescale 1ns/1ps
`default_nettype none
module dpr_infl_cnt
    import dpr_pkg::*;
#(
    parameter int MAX_INFL = DPR_MAX_INFL
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    dpr_infl_if.cnt link
);
    if (MAX_INFL < 1 || MAX_INFL >= (1 << DPR_INFL_W)) begin : g_bad_max_infl
        $error("MAX_INFL out of range");
    end

    logic [DPR_INFL_W-1:0] count_r;
    logic [DPR_INFL_W-1:0] count_nxt;
    // A completion at zero is refused, so an issue beside it still counts
    wire done_live = link.done && (count_r != '0);
    wire up = link.issue && !done_live;
    wire down = done_live && !link.issue;

    assign count_nxt = up ? count_r + 4'h1 : (down ? count_r - 4'h1 : count_r);

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign link.count = count_r;
    assign link.busy = (count_r != '0);
endmodule
`default_nettype wire

//--- logic/dpr_channel.sv
// Purpose: DMA channel pointers and count with in-flight adjusted readback
// Assumes: bus pipeline strobes are on clock_i; starts only while idle
// Notes: pointer readback keeps the linear correction in every mode
`timescale 1ns/1ps
`default_nettype none
module dpr_channel
    import dpr_pkg::*;
#(
    parameter int MAX_INFL = DPR_MAX_INFL
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [31:0] src_start_i,
    input wire logic [31:0] dst_start_i,
    input wire logic [31:0] count_start_i,
    input wire logic [1:0] size_i,
    input wire logic source_step_enable_i,
    input wire logic dest_step_enable_i,
    input wire logic [3:0] ring_size_i,
    input wire logic ring_on_write_i,
    input wire logic rd_issue_i,
    input wire logic rd_done_i,
    input wire logic wr_issue_i,
    input wire logic wr_done_i,
    output logic rd_req_o,
    output logic wr_req_o,
    output logic busy_o,
    output logic [31:0] src_read_o,
    output logic [31:0] dst_read_o,
    output logic [31:0] remaining_transfers_o
);
    if (MAX_INFL < 1 || MAX_INFL >= (1 << DPR_INFL_W)) begin : g_bad_max_infl
        $error("MAX_INFL out of range");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dpr_state_e state_r, state_nxt;
    logic [31:0] src_r, dst_r, rd_left_r, wr_left_r;
    logic [1:0] size_r;
    logic src_step_r, dst_step_r, ring_wr_r;
    logic [3:0] ring_r;

    // One in-flight counter per direction; the two sides complete independently
    dpr_infl_if rd_if ();
    dpr_infl_if wr_if ();

    dpr_infl_cnt #(.MAX_INFL(MAX_INFL)) u_rd_cnt (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .link(rd_if.cnt)
    );
    dpr_infl_cnt #(.MAX_INFL(MAX_INFL)) u_wr_cnt (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .link(wr_if.cnt)
    );

    // ------------------------------------------------------------
    // Issue gating and pointer stepping
    // ------------------------------------------------------------
    wire running = (state_r == DPR_RUN);
    wire [31:0] step = dpr_bytes(size_r);
    // Issue only accepted while requested and the counter has room
    wire rd_ok = rd_issue_i && rd_req_o;
    wire wr_ok = wr_issue_i && wr_req_o;
    assign rd_if.issue = rd_ok;
    assign rd_if.done = rd_done_i;
    assign wr_if.issue = wr_ok;
    assign wr_if.done = wr_done_i;

    // Wrap keeps the low ring bits moving and freezes the rest
    function automatic logic [31:0] dpr_advance(input logic [31:0] a, input logic [31:0] s,
                                                input logic en, input logic [3:0] ring,
                                                input logic wrap_here);
        logic [31:0] sum;
        logic [31:0] mask;
        sum = a + s;
        mask = (32'h0000_0001 << ring) - 32'h0000_0001;
        if (!en) begin
            dpr_advance = a;
        end else if (wrap_here && ring != DPR_RING_OFF) begin
            dpr_advance = (a & ~mask) | (sum & mask);
        end else begin
            dpr_advance = sum;
        end
    endfunction

    wire [31:0] src_nxt = dpr_advance(src_r, step, src_step_r, ring_r, !ring_wr_r);
    wire [31:0] dst_nxt = dpr_advance(dst_r, step, dst_step_r, ring_r, ring_wr_r);

    // Linear correction, blind to stepping and wrap on purpose
    wire [31:0] rd_infl = {{(32-DPR_INFL_W){1'b0}}, rd_if.count};
    wire [31:0] wr_infl = {{(32-DPR_INFL_W){1'b0}}, wr_if.count};
    wire [31:0] src_corr = src_r - 32'(rd_infl * step);
    wire [31:0] dst_corr = dst_r - 32'(wr_infl * step);
    // Count falls at write issue, so in-flight writes are added back
    wire [31:0] cnt_corr = wr_left_r + wr_infl;

    // Room is judged after this edge's issue, else a held request overshoots the limit
    wire [DPR_INFL_W:0] rd_infl_nxt = {1'b0, rd_if.count} + {{DPR_INFL_W{1'b0}}, rd_ok};
    wire [DPR_INFL_W:0] wr_infl_nxt = {1'b0, wr_if.count} + {{DPR_INFL_W{1'b0}}, wr_ok};
    wire infl_room_rd = (rd_infl_nxt < (DPR_INFL_W + 1)'(MAX_INFL));
    wire infl_room_wr = (wr_infl_nxt < (DPR_INFL_W + 1)'(MAX_INFL));
    wire rd_req_nxt = (state_nxt == DPR_RUN) && (rd_left_r - (rd_ok ? 32'h1 : 32'h0)) != '0
                      && infl_room_rd;
    wire wr_req_nxt = (state_nxt == DPR_RUN) && (wr_left_r - (wr_ok ? 32'h1 : 32'h0)) != '0
                      && infl_room_wr;

    // ------------------------------------------------------------
    // Sequence control
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DPR_IDLE: begin
                if (start_i && count_start_i != '0) begin
                    state_nxt = DPR_RUN;
                end
            end
            DPR_RUN: begin
                if (wr_left_r == '0 || (wr_left_r == 32'h1 && wr_ok)) begin
                    state_nxt = DPR_DRAIN;
                end
            end
            // Idle only once both directions have drained
            DPR_DRAIN: begin
                if (!rd_if.busy && !wr_if.busy) begin
                    state_nxt = DPR_IDLE;
                end
            end
            default: state_nxt = DPR_IDLE;
        endcase
    end

    wire seq_load = (state_r == DPR_IDLE) && start_i;
    wire rd_step = running && rd_ok;
    wire wr_step = running && wr_ok;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= DPR_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Mode bits are frozen for the whole sequence
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            size_r <= DPR_SIZE_WORD;
            src_step_r <= 1'b0;
            dst_step_r <= 1'b0;
            ring_r <= DPR_RING_OFF;
            ring_wr_r <= 1'b0;
        end else if (seq_load) begin
            size_r <= size_i;
            src_step_r <= source_step_enable_i;
            dst_step_r <= dest_step_enable_i;
            ring_r <= ring_size_i;
            ring_wr_r <= ring_on_write_i;
        end
    end

    // Each direction keeps its own pointer and transfers left
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_r <= DPR_ADDR_RST;
            rd_left_r <= DPR_CNT_RST;
        end else if (seq_load) begin
            src_r <= src_start_i;
            rd_left_r <= count_start_i;
        end else if (rd_step) begin
            src_r <= src_nxt;
            rd_left_r <= rd_left_r - 32'h1;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dst_r <= DPR_ADDR_RST;
            wr_left_r <= DPR_CNT_RST;
        end else if (seq_load) begin
            dst_r <= dst_start_i;
            wr_left_r <= count_start_i;
        end else if (wr_step) begin
            dst_r <= dst_nxt;
            wr_left_r <= wr_left_r - 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Readbacks trail the internal state by one edge so software sees settled values
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_req_o <= 1'b0;
            wr_req_o <= 1'b0;
            busy_o <= 1'b0;
            src_read_o <= DPR_ADDR_RST;
            dst_read_o <= DPR_ADDR_RST;
            remaining_transfers_o <= DPR_CNT_RST;
        end else begin
            rd_req_o <= rd_req_nxt;
            wr_req_o <= wr_req_nxt;
            busy_o <= (state_nxt != DPR_IDLE);
            src_read_o <= src_corr;
            dst_read_o <= dst_corr;
            remaining_transfers_o <= cnt_corr;
        end
    end
endmodule
`default_nettype wire

//--- bench/dpr_channel_properties.sv
// Purpose: port-level checks on the progress readback channel
// Assumes: strobes are one-cycle pulses; readbacks trail state by a cycle
// Notes: a completion must shift the readback by one transfer in every mode
`timescale 1ns/1ps
`default_nettype none
module dpr_props (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic start_i,
    input wire logic [31:0] src_start_i,
    input wire logic [31:0] count_start_i,
    input wire logic [1:0] size_i,
    input wire logic source_step_enable_i,
    input wire logic [3:0] ring_size_i,
    input wire logic ring_on_write_i,
    input wire logic rd_issue_i,
    input wire logic rd_done_i,
    input wire logic wr_issue_i,
    input wire logic wr_done_i,
    input wire logic rd_req_o,
    input wire logic wr_req_o,
    input wire logic busy_o,
    input wire logic [31:0] src_read_o,
    input wire logic [31:0] dst_read_o,
    input wire logic [31:0] remaining_transfers_o
);
    wire logic [31:0] sz = size_i[1] ? 32'h4 : (size_i[0] ? 32'h2 : 32'h1);
    wire logic rd_take = busy_o && rd_issue_i && rd_req_o;
    wire logic wr_take = busy_o && wr_issue_i && wr_req_o;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    chk_rd_done_step: assert property (
        busy_o && rd_done_i && !rd_issue_i |-> ##2 src_read_o == $past(src_read_o) + sz)
        else $error("read completion did not advance source readback");
    chk_wr_done_step: assert property (
        busy_o && wr_done_i && !wr_issue_i |-> ##2 dst_read_o == $past(dst_read_o) + sz)
        else $error("write completion did not advance dest readback");
    chk_issue_linear: assert property (
        rd_take && !rd_done_i && source_step_enable_i && (ring_size_i == 4'h0 || ring_on_write_i)
        |-> ##2 $stable(src_read_o)) else $error("issue moved linear readback");
    chk_issue_fixed_dip: assert property (
        rd_take && !rd_done_i && !source_step_enable_i
        |-> ##2 src_read_o == $past(src_read_o) - sz) else $error("fixed readback not lowered");
    chk_count_issue_flat: assert property (
        wr_take && !wr_done_i |-> ##2 $stable(remaining_transfers_o))
        else $error("write issue moved corrected count");
    chk_count_done_step: assert property (
        busy_o && wr_done_i && !wr_issue_i
        |-> ##2 remaining_transfers_o == $past(remaining_transfers_o) - 32'h1)
        else $error("write completion did not lower count");
    chk_start_load: assert property (
        !busy_o && start_i && count_start_i != 32'h0 |-> ##2
        src_read_o == $past(src_start_i, 2) && remaining_transfers_o == $past(count_start_i, 2))
        else $error("start values not reported");
    chk_idle_quiet: assert property (
        !busy_o |-> !rd_req_o && !wr_req_o) else $error("request while idle");
    cover property (busy_o && rd_done_i);
    cover property (rd_take && !source_step_enable_i);
    cover property (wr_take && ring_size_i != 4'h0);
endmodule
`default_nettype wire

//--- bench/dpr_bus_model.sv
// Purpose: bus pipeline stand-in that issues and completes accesses
// Assumes: called on the falling clock edge
// Notes: an issue waits, bounded, for the channel's request
`timescale 1ns/1ps
`default_nettype none
module dpr_bus_model (
    input wire logic clock_i,
    input wire logic rd_req_i,
    input wire logic wr_req_i,
    output logic rd_issue_o,
    output logic rd_done_o,
    output logic wr_issue_o,
    output logic wr_done_o
);
    logic [3:0] strobe = 4'h0;
    assign {wr_done_o, wr_issue_o, rd_done_o, rd_issue_o} = strobe;
    // Hold one strobe for n edges, sel is {write, done}; idle gap after
    task automatic pulse(input logic [1:0] sel, input int n, output bit ok);
        int w;
        w = 0;
        while (!sel[0] && (sel[1] ? wr_req_i : rd_req_i) !== 1'b1 && w < 40) begin
            @(negedge clock_i);
            w++;
        end
        ok = w < 40;
        if (ok) begin
            strobe[sel] = 1'b1;
            repeat (n) @(negedge clock_i);
            strobe = 4'h0;
            @(negedge clock_i);
        end
    endtask
endmodule
`default_nettype wire

//--- bench/dpr_progress_readback_tb.sv
// Purpose: self-checking bench for the progress readback channel
// Assumes: bus model stands in for the pipeline
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module dpr_progress_readback_tb;
    import dpr_pkg::*;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic start_i = 1'b0;
    logic [31:0] src_s = 32'h0, dst_s = 32'h0, cnt_s = 32'h0, src_rd, dst_rd, rem;
    logic [1:0] size = 2'h0;
    logic [3:0] ring = 4'h0;
    logic s_step = 1'b1, d_step = 1'b1, ring_w = 1'b0;
    logic rd_iss, rd_dn, wr_iss, wr_dn, rd_req, wr_req, busy;
    int mismatches = 0;
    int checks_done = 0;
    bit ok;
    always #4 clock_i = ~clock_i;
    dpr_channel i_dut (.clock_i, .rstn_i, .start_i, .src_start_i(src_s), .dst_start_i(dst_s),
        .count_start_i(cnt_s), .size_i(size), .source_step_enable_i(s_step),
        .dest_step_enable_i(d_step), .ring_size_i(ring), .ring_on_write_i(ring_w),
        .rd_issue_i(rd_iss), .rd_done_i(rd_dn), .wr_issue_i(wr_iss), .wr_done_i(wr_dn),
        .rd_req_o(rd_req), .wr_req_o(wr_req), .busy_o(busy), .src_read_o(src_rd),
        .dst_read_o(dst_rd), .remaining_transfers_o(rem));
    dpr_bus_model i_bus (.clock_i, .rd_req_i(rd_req), .wr_req_i(wr_req), .rd_issue_o(rd_iss),
        .rd_done_o(rd_dn), .wr_issue_o(wr_iss), .wr_done_o(wr_dn));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic bus(input logic [1:0] sel, input int n);
        i_bus.pulse(sel, n, ok);
        if (!ok) begin
            mismatches++;
            end_of_test();
        end
        repeat (2) @(negedge clock_i);
    endtask
    task automatic go(input logic [31:0] s, d, c, input logic [1:0] z, input logic [3:0] r);
        {src_s, dst_s, cnt_s, size, ring, start_i} = {s, d, c, z, r, 1'b1};
        @(negedge clock_i);
        start_i = 1'b0;
        @(negedge clock_i);
        `CHK(busy, 1'b1)
    endtask
    task automatic drain();
        int w;
        for (w = 0; w < 40 && busy !== 1'b0; w++) @(negedge clock_i);
        `CHK(busy, 1'b0)
        if (w == 40) end_of_test();
    endtask
    task automatic run_reset();
        {s_step, d_step, ring_w} = 3'b110;
        go(32'h6000, 32'h7000, 32'h4, DPR_SIZE_WORD, 4'h0);
        bus(2'h0, 2);
        `CHK(src_rd, 32'h6000)
        rstn_i = 1'b0;
        @(negedge clock_i);
        `CHK({busy, rd_req, wr_req, src_rd, dst_rd, rem}, 99'h0)
        rstn_i = 1'b1;
        repeat (2) @(negedge clock_i);
        `CHK({busy, rd_req, wr_req, src_rd, dst_rd, rem}, 99'h0)
    endtask
    task automatic run_linear();
        {s_step, d_step, ring_w} = 3'b110;
        go(32'h1000, 32'h2000, 32'h3, DPR_SIZE_BYTE, 4'h0);
        bus(2'h0, 2);
        `CHK(src_rd, 32'h1000)
        bus(2'h1, 1);
        `CHK(src_rd, 32'h1001)
        bus(2'h2, 1);
        `CHK(rem, 32'h3)
        bus(2'h3, 1);
        `CHK({rem, dst_rd}, {32'h2, 32'h2001})
        bus(2'h0, 1);
        bus(2'h1, 2);
        bus(2'h2, 2);
        bus(2'h3, 2);
        drain();
        `CHK(src_rd, 32'h1003)
    endtask
    task automatic run_fixed();
        {s_step, d_step, ring_w} = 3'b000;
        go(32'h3000, 32'h4000, 32'h2, DPR_SIZE_HALF, 4'h0);
        bus(2'h0, 2);
        `CHK(src_rd, 32'h2ffc)
        bus(2'h2, 2);
        `CHK({dst_rd, rem}, {32'h3ffc, 32'h2})
        bus(2'h1, 2);
        bus(2'h3, 2);
        drain();
        `CHK({src_rd, dst_rd, rem}, {32'h3000, 32'h4000, 32'h0})
    endtask
    task automatic run_wrap();
        {s_step, d_step, ring_w} = 3'b111;
        go(32'h5000, 32'h2000, 32'h6, 2'h3, 4'h4);
        bus(2'h2, 5);
        `CHK(dst_rd, 32'h1ff0)
        `CHK(rem, 32'h6)
        bus(2'h3, 5);
        `CHK(dst_rd, 32'h2004)
        `CHK(32'h2000 + (((32'h6 - rem) * 32'h4) & 32'hf), 32'h2004)
        bus(2'h2, 1);
        bus(2'h3, 1);
        drain();
        `CHK(dst_rd, 32'h2008)
    endtask
    initial begin
        repeat (10) @(negedge clock_i);
        rstn_i = 1'b1;
        @(negedge clock_i);
        run_reset();
        run_linear();
        run_fixed();
        run_wrap();
        end_of_test();
    end
endmodule
bind dpr_channel dpr_props i_props (.clock_i, .rstn_i, .start_i, .src_start_i, .count_start_i,
    .size_i, .source_step_enable_i, .ring_size_i, .ring_on_write_i, .rd_issue_i, .rd_done_i,
    .wr_issue_i, .wr_done_i, .rd_req_o, .wr_req_o, .busy_o, .src_read_o, .dst_read_o,
    .remaining_transfers_o);
`default_nettype wire
